// ### adc_clock_sample_scan_ctrl.sv
// conversion clock, auto-sample timing and input scan control with apb registers
// assumes the converter answers each convert_start with a conv_done rise
// Contract
// - clock source bit picks rc oscillator or bus
// - bus period times two times divider plus one
// - divider ignored while rc oscillator selected
// - auto-sample lasts field value conversion periods; the code runs 32 periods for a field of zero
// - auto-sample field used only for trigger 111
// - mask bit n includes analog input n
// - unused bits read zero, writes ignored
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module adc_clock_sample_scan_ctrl (
    input wire logic mclk,
    input wire logic rstn,
    input wire adc_ctrl_pkg::apb_req_s apb_req,
    output adc_ctrl_pkg::apb_rsp_s apb_rsp,
    input wire logic rc_osc_in,
    input wire logic ext_trigger,
    input wire logic conv_done,
    output adc_ctrl_pkg::adc_out_s adc_out
);

    typedef struct packed {
        adc_ctrl_pkg::cfg_s cfg;
        logic [15:0] scan_input_mask;
        logic [2:0] conversion_trigger_sel;
        logic scan_en;
        logic [3:0] fixed_chan;
        adc_ctrl_pkg::phase_e phase;
        logic [8:0] div_cnt;
        logic [4:0] samp_cnt;
        logic [2:0] rc_sync;
        logic rc_level;
        logic [2:0] trg_sync;
        logic trg_level;
        logic [2:0] done_sync;
        logic done_level;
        logic [3:0] chan;
        logic conv_clk;
        logic period_tick;
        logic convert_start;
        logic [31:0] prdata;
        logic pslverr;
    } state_s;

    state_s st;
    state_s next_st;
    logic tick;
    logic trg_rise;
    logic done_rise;
    logic wr_en;
    logic setup;

    // next masked channel after c, wrapping; c itself when mask is empty
    function automatic logic [3:0] next_chan(input logic [15:0] m, input logic [3:0] c);
        logic [3:0] r;
        logic f;
        logic [3:0] k;
        r = c;
        f = 1'b0;
        for (int i = 1; i <= 16; i++) begin
            k = c + i[3:0];
            if (!f && m[k]) begin
                r = k;
                f = 1'b1;
            end
        end
        return r;
    endfunction

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] cfg_word(input adc_ctrl_pkg::cfg_s c);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[adc_ctrl_pkg::src_pos] = c.conv_clock_source_sel;
        r[adc_ctrl_pkg::sample_pos +: 5] = c.auto_sample_periods;
        r[adc_ctrl_pkg::div_pos +: 8] = c.conv_clock_divider;
        return r;
    endfunction

    always_comb begin
        logic [31:0] w;
        logic [31:0] rd;
        logic err;
        logic start;
        w = 32'h0000_0000;
        rd = 32'h0000_0000;
        err = 1'b0;
        start = 1'b0;
        next_st = st;
        setup = apb_req.psel && !apb_req.penable;
        wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;

        // three-stage pin synchronisers, level moves once stages two and three agree
        next_st.rc_sync = {st.rc_sync[1:0], rc_osc_in};
        next_st.trg_sync = {st.trg_sync[1:0], ext_trigger};
        next_st.done_sync = {st.done_sync[1:0], conv_done};
        if (st.rc_sync[1] == st.rc_sync[2]) begin
            next_st.rc_level = st.rc_sync[2];
        end
        if (st.trg_sync[1] == st.trg_sync[2]) begin
            next_st.trg_level = st.trg_sync[2];
        end
        if (st.done_sync[1] == st.done_sync[2]) begin
            next_st.done_level = st.done_sync[2];
        end
        trg_rise = next_st.trg_level && !st.trg_level;
        done_rise = next_st.done_level && !st.done_level;

        // conversion clock source
        if (st.cfg.conv_clock_source_sel) begin
            // divider held still, its field has no effect here
            tick = next_st.rc_level && !st.rc_level;
            next_st.div_cnt = adc_ctrl_pkg::cnt_reset;
            next_st.conv_clk = next_st.rc_level;
        end else begin
            // period is 2*(divider+1) bus clocks
            tick = (st.div_cnt == {st.cfg.conv_clock_divider, 1'b1});
            if (tick) begin
                next_st.div_cnt = adc_ctrl_pkg::cnt_reset;
            end else begin
                next_st.div_cnt = st.div_cnt + 9'h001;
            end
            next_st.conv_clk = (next_st.div_cnt > {1'b0, st.cfg.conv_clock_divider});
        end
        next_st.period_tick = tick;

        // register reads are captured in the setup cycle so data leaves a flip-flop
        if (setup) begin
            if (apb_req.paddr == adc_ctrl_pkg::off_cfg) begin
                rd = cfg_word(st.cfg);
            end else if (apb_req.paddr == adc_ctrl_pkg::off_mask) begin
                rd = {16'h0000, st.scan_input_mask};
            end else if (apb_req.paddr == adc_ctrl_pkg::off_main) begin
                rd[adc_ctrl_pkg::scan_pos] = st.scan_en;
                rd[adc_ctrl_pkg::trig_pos +: 3] = st.conversion_trigger_sel;
                rd[adc_ctrl_pkg::fixch_pos +: 4] = st.fixed_chan;
            end else if (apb_req.paddr == adc_ctrl_pkg::off_stat) begin
                rd[0] = (st.phase == adc_ctrl_pkg::st_sample);
                rd[1] = (st.phase == adc_ctrl_pkg::st_convert);
                rd[7:4] = st.chan;
            end else begin
                err = 1'b1;
            end
            next_st.prdata = rd;
            next_st.pslverr = err;
        end

        // writes land in the access cycle; unused bits are dropped
        if (wr_en && !st.pslverr) begin
            if (apb_req.paddr == adc_ctrl_pkg::off_cfg) begin
                w = merge(cfg_word(st.cfg), apb_req.pwdata, apb_req.pstrb);
                next_st.cfg.conv_clock_source_sel = w[adc_ctrl_pkg::src_pos];
                next_st.cfg.auto_sample_periods = w[adc_ctrl_pkg::sample_pos +: 5];
                next_st.cfg.conv_clock_divider = w[adc_ctrl_pkg::div_pos +: 8];
                // restart so a smaller divider never overruns the count
                next_st.div_cnt = adc_ctrl_pkg::cnt_reset;
            end else if (apb_req.paddr == adc_ctrl_pkg::off_mask) begin
                w = merge({16'h0000, st.scan_input_mask}, apb_req.pwdata, apb_req.pstrb);
                next_st.scan_input_mask = w[15:0];
            end else if (apb_req.paddr == adc_ctrl_pkg::off_main) begin
                w = merge(32'h0000_0000, apb_req.pwdata, apb_req.pstrb);
                next_st.scan_en = w[adc_ctrl_pkg::scan_pos];
                next_st.conversion_trigger_sel = w[adc_ctrl_pkg::trig_pos +: 3];
                next_st.fixed_chan = w[adc_ctrl_pkg::fixch_pos +: 4];
                start = w[adc_ctrl_pkg::start_pos];
            end
        end

        next_st.convert_start = 1'b0;
        case (st.phase)
            adc_ctrl_pkg::st_idle: begin
                if (start) begin
                    next_st.phase = adc_ctrl_pkg::st_sample;
                    next_st.samp_cnt = 5'h00;
                    // restart the divider so the first bus-derived period is whole
                    if (!st.cfg.conv_clock_source_sel) begin
                        next_st.div_cnt = adc_ctrl_pkg::cnt_reset;
                    end
                    if (next_st.scan_en) begin
                        if (!st.scan_input_mask[st.chan]) begin
                            next_st.chan = next_chan(st.scan_input_mask, st.chan);
                        end
                    end else begin
                        next_st.chan = next_st.fixed_chan;
                    end
                end
            end
            adc_ctrl_pkg::st_sample: begin
                if (st.conversion_trigger_sel == adc_ctrl_pkg::trig_auto) begin
                    // sampling runs auto_sample_periods conversion periods, 32 when the field is zero
                    if (tick) begin
                        next_st.samp_cnt = st.samp_cnt + 5'h01;
                        if (st.samp_cnt == st.cfg.auto_sample_periods - 5'h01) begin
                            next_st.phase = adc_ctrl_pkg::st_convert;
                            next_st.convert_start = 1'b1;
                        end
                    end
                end else if (trg_rise) begin
                    // other sources end sampling on the external trigger
                    next_st.phase = adc_ctrl_pkg::st_convert;
                    next_st.convert_start = 1'b1;
                end
            end
            adc_ctrl_pkg::st_convert: begin
                if (done_rise) begin
                    next_st.phase = adc_ctrl_pkg::st_idle;
                    if (st.scan_en) begin
                        next_st.chan = next_chan(st.scan_input_mask, st.chan);
                    end
                end
            end
            default: begin
                next_st.phase = adc_ctrl_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.cfg.conv_clock_divider <= adc_ctrl_pkg::div_reset;
            st.cfg.auto_sample_periods <= adc_ctrl_pkg::sample_reset;
            st.scan_input_mask <= adc_ctrl_pkg::mask_reset;
            st.conversion_trigger_sel <= adc_ctrl_pkg::trig_reset;
            st.chan <= adc_ctrl_pkg::chan_reset;
            st.div_cnt <= adc_ctrl_pkg::cnt_reset;
            st.phase <= adc_ctrl_pkg::st_idle;
        end else begin
            st <= next_st;
        end
    end

    // zero wait states: every access completes in its first access cycle
    assign apb_rsp.prdata = st.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = st.pslverr;
    assign adc_out.conv_clk = st.conv_clk;
    assign adc_out.period_tick = st.period_tick;
    assign adc_out.sample_active = (st.phase == adc_ctrl_pkg::st_sample);
    assign adc_out.convert_start = st.convert_start;
    assign adc_out.scan_channel = st.chan;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    rc_src_tick_a: assert property (
        (st.cfg.conv_clock_source_sel && $past(st.cfg.conv_clock_source_sel))
        |-> (st.period_tick == (st.rc_level && !$past(st.rc_level))))
        else $error("rc tick does not follow oscillator edge");

    div_tick_a: assert property (
        (!st.cfg.conv_clock_source_sel && !$past(st.cfg.conv_clock_source_sel)
         && st.period_tick && $stable(st.cfg.conv_clock_divider))
        |-> ($past(st.div_cnt) == {st.cfg.conv_clock_divider, 1'b1}))
        else $error("bus tick at wrong divider count");

    div_range_a: assert property (
        (!st.cfg.conv_clock_source_sel && $stable(st.cfg.conv_clock_divider)
         && $past(!st.cfg.conv_clock_source_sel))
        |-> (st.div_cnt <= {st.cfg.conv_clock_divider, 1'b1}))
        else $error("divider count out of range");

    rc_hold_a: assert property (
        $past(st.cfg.conv_clock_source_sel) |-> (st.div_cnt == adc_ctrl_pkg::cnt_reset))
        else $error("divider counts while rc selected");

    samp_len_a: assert property (
        ($past(st.phase) == adc_ctrl_pkg::st_sample && st.phase == adc_ctrl_pkg::st_convert
         && $past(st.conversion_trigger_sel) == adc_ctrl_pkg::trig_auto)
        |-> ($past(st.samp_cnt) == 5'($past(st.cfg.auto_sample_periods) - 5'h01)))
        else $error("auto sample ended at wrong period count");

    trig_end_a: assert property (
        (st.phase == adc_ctrl_pkg::st_sample && st.conversion_trigger_sel != adc_ctrl_pkg::trig_auto
         && !trg_rise)
        |=> (st.phase == adc_ctrl_pkg::st_sample))
        else $error("sampling ended without trigger");

    scan_mask_a: assert property (
        (st.convert_start && st.scan_en && (st.scan_input_mask != 16'h0000)
         && $stable(st.scan_input_mask))
        |-> st.scan_input_mask[st.chan])
        else $error("scan converts unselected input");

    rsvd_zero_a: assert property (
        (apb_req.psel && apb_req.penable && !apb_req.pwrite
         && $past(setup) && apb_req.paddr == adc_ctrl_pkg::off_cfg)
        |-> (apb_rsp.prdata[31:16] == 16'h0000 && apb_rsp.prdata[14:13] == 2'b00))
        else $error("reserved bits read nonzero");

    sync_path_a: assert property (
        $rose(st.done_level) |-> ($past(st.done_sync[1]) && $past(st.done_sync[2])))
        else $error("done level moved before synchroniser agreed");

endmodule

// ### adc_ctrl_pkg.sv
// constants, register layout and carrier types of the converter timing block
// assumes an apb master on the same clock as the block
package adc_ctrl_pkg;
    localparam logic [11:0] off_cfg = 12'h000;
    localparam logic [11:0] off_mask = 12'h004;
    localparam logic [11:0] off_main = 12'h008;
    localparam logic [11:0] off_stat = 12'h00c;
    localparam int src_pos = 15;
    localparam int sample_pos = 8;
    localparam int div_pos = 0;
    localparam int start_pos = 0;
    localparam int scan_pos = 1;
    localparam int trig_pos = 5;
    localparam int fixch_pos = 8;
    localparam logic [2:0] trig_auto = 3'h7;
    localparam logic [15:0] mask_reset = 16'h0000;
    localparam logic [7:0] div_reset = 8'h00;
    localparam logic [4:0] sample_reset = 5'h00;
    localparam logic [2:0] trig_reset = 3'h0;
    localparam logic [3:0] chan_reset = 4'h0;
    localparam logic [8:0] cnt_reset = 9'h000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic conv_clk;
        logic period_tick;
        logic sample_active;
        logic convert_start;
        logic [3:0] scan_channel;
    } adc_out_s;

    typedef struct packed {
        logic conv_clock_source_sel;
        logic [4:0] auto_sample_periods;
        logic [7:0] conv_clock_divider;
    } cfg_s;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_sample = 3'b010,
        st_convert = 3'b100
    } phase_e;
endpackage

// ### adc_conv_model.sv
// stand-in for the sample-and-hold and converter behind the timing block
// assumes convert_start is a one-cycle pulse on mclk and conv_done is seen through a synchroniser
`timescale 1ns/1ps
module adc_conv_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic convert_start,
    input wire logic slow,
    output logic conv_done
);
    int cnt;

    // completion is a three-cycle level so the three-flop synchroniser cannot miss it
    // slow stretches the conversion to check that nothing moves before completion
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            conv_done <= 1'b0;
        end else if (convert_start) begin
            cnt <= slow ? 24 : 4;
            conv_done <= 1'b0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            conv_done <= (cnt <= 3);
        end else begin
            conv_done <= 1'b0;
        end
    end
endmodule

// ### tb.sv
// self-checking bench of the converter timing block: apb master, rc pin, trigger, converter model
// assumes one 100 MHz clock and the register map of adc_ctrl_pkg
`timescale 1ns/1ps
module tb;
    logic mclk;
    logic rstn;
    adc_ctrl_pkg::apb_req_s apb_req;
    adc_ctrl_pkg::apb_rsp_s apb_rsp;
    adc_ctrl_pkg::adc_out_s adc_out;
    logic rc_osc_in;
    logic ext_trigger;
    logic conv_done;
    logic slow;
    logic [31:0] rd;
    logic err;
    logic [7:0] div;
    logic [4:0] nsamp;
    logic [15:0] m;
    logic [3:0] ch;
    int fails;
    int tests_run;
    int seed;
    int ticks;
    int gap;
    int cyc;
    int hits;
    int hi;

    adc_clock_sample_scan_ctrl i_dut (.mclk(mclk), .rstn(rstn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .rc_osc_in(rc_osc_in), .ext_trigger(ext_trigger),
        .conv_done(conv_done), .adc_out(adc_out));
    adc_conv_model i_conv (.mclk(mclk), .rstn(rstn), .convert_start(adc_out.convert_start),
        .slow(slow), .conv_done(conv_done));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // free-running oscillator, period 83 ns, unrelated to mclk
    initial begin
        rc_osc_in = 1'b0;
        // start offset keeps every oscillator edge off the mclk edges
        #1.3;
        forever #41.5 rc_osc_in = ~rc_osc_in;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one transfer; an idle edge before setup keeps release and next request apart
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge mclk);
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= addr;
        apb_req.pwdata <= wdata;
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        @(posedge mclk);
        while (apb_rsp.pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // start, count ticks, clock-high cycles and last tick spacing until convert_start
    task automatic convert(input logic [31:0] main);
        int last;
        ticks = 0;
        gap = 0;
        cyc = 0;
        hi = 0;
        last = 0;
        apb(1'b1, adc_ctrl_pkg::off_main, main);
        while (adc_out.convert_start !== 1'b1) begin
            @(posedge mclk);
            cyc++;
            if (cyc == 1)
                check(adc_out.sample_active, 1'b1);
            // a tick seen in the first cycle was launched by the write cycle, not by sampling
            if (cyc > 1 && adc_out.period_tick === 1'b1) begin
                ticks++;
                if (ticks > 1)
                    gap = cyc - last;
                last = cyc;
            end
            if (cyc > 1 && adc_out.conv_clk === 1'b1)
                hi++;
        end
        ch = adc_out.scan_channel;
        check(adc_out.sample_active, 1'b0);
        repeat (40) @(posedge mclk);
    endtask

    function automatic logic [3:0] next_chan(input logic [15:0] mk, input logic [3:0] c);
        logic [3:0] k;
        next_chan = c;
        for (int i = 16; i >= 1; i--) begin
            k = c + i[3:0];
            if (mk[k])
                next_chan = k;
        end
    endfunction

    initial begin
        #300_000;
        fails++;
        summarize();
    end

    initial begin
        seed = 32'h1efd;
        fails = 0;
        tests_run = 0;
        rstn = 1'b0;
        apb_req = '0;
        apb_req.pstrb = 4'hf;
        ext_trigger = 1'b0;
        slow = 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        apb(1'b0, adc_ctrl_pkg::off_cfg, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, adc_ctrl_pkg::off_mask, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b1, adc_ctrl_pkg::off_cfg, 32'hffff_ffff);
        apb(1'b0, adc_ctrl_pkg::off_cfg, 32'h0000_0000);
        check(rd, 32'h0000_9fff);
        apb(1'b1, adc_ctrl_pkg::off_mask, 32'hffff_ffff);
        apb(1'b0, adc_ctrl_pkg::off_mask, 32'h0000_0000);
        check(rd, 32'h0000_ffff);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0001);
        // bus clock: random divider and sample length, boundary cases first
        for (int t = 0; t < 6; t++) begin
            div = 8'($random(seed)) & 8'h07;
            nsamp = 5'(({$random(seed)} % 31) + 1);
            if (t == 0) begin
                div = 8'h00;
                nsamp = 5'h01;
            end
            if (t == 1) begin
                div = 8'hff;
                nsamp = 5'h02;
            end
            if (t == 2)
                nsamp = 5'h1f;
            apb(1'b1, adc_ctrl_pkg::off_cfg, {19'h0_0000, nsamp, div});
            convert(32'h0000_00e1);
            check(ticks, nsamp);
            check(hi, nsamp * (div + 1));
            if (nsamp > 1)
                check(gap, 2 * (div + 1));
        end
        // rc oscillator selected: divider of 255 must not matter
        apb(1'b1, adc_ctrl_pkg::off_cfg, 32'h0000_83ff);
        convert(32'h0000_00e1);
        check(ticks, 3);
        check(gap == 8 || gap == 9, 1'b1);
        // other trigger source: sample length ignored, trigger pin ends sampling
        apb(1'b1, adc_ctrl_pkg::off_cfg, 32'h0000_0100);
        apb(1'b1, adc_ctrl_pkg::off_main, 32'h0000_0001);
        hits = 0;
        repeat (100) begin
            @(posedge mclk);
            if (adc_out.convert_start === 1'b1)
                hits++;
        end
        check(hits, 0);
        apb(1'b0, adc_ctrl_pkg::off_stat, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        ext_trigger <= 1'b1;
        cyc = 0;
        while (adc_out.convert_start !== 1'b1 && cyc < 50) begin
            @(posedge mclk);
            cyc++;
        end
        ext_trigger <= 1'b0;
        check(cyc >= 4 && cyc <= 6, 1'b1);
        repeat (40) @(posedge mclk);
        // scan: each conversion on a masked input, next one is the next masked input
        for (int t = 0; t < 4; t++) begin
            m = (t == 0) ? 16'h8000 : 16'($random(seed));
            if (m == 16'h0000)
                m = 16'h8001;
            apb(1'b1, adc_ctrl_pkg::off_mask, {16'h0000, m});
            for (int k = 0; k < 4; k++) begin
                slow <= k[0];
                convert(32'h0000_00e3);
                check(m[ch], 1'b1);
                check(adc_out.scan_channel, next_chan(m, ch));
            end
        end
        apb(1'b0, adc_ctrl_pkg::off_main, 32'h0000_0000);
        check(rd, 32'h0000_00e2);
        summarize();
    end
endmodule
